// ### design/pfm_axis_mon.sv
// pfm_axis_mon: one photosensor pair with its motor command; flags overlap,
// stuck motion and wrong-order limits. inputs are already synchronised.
`timescale 1ns/1ps
module pfm_axis_mon
    import pfm_pkg::*;
#(
    parameter int unsigned STUCK_CYCLES = STUCK_CYC
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic sens_a,
    input  wire logic sens_b,
    input  wire logic motor_on,
    output logic      overlap,
    output logic      stuck,
    output logic      b_first,
    output logic      a_first
);
    typedef struct packed {
        logic             a;
        logic             b;
        logic [CNT_W-1:0] cnt;
        logic             ovl;
        logic             stk;
        logic             bf;
        logic             af;
    } pfm_ax_t;

    pfm_ax_t st_q;
    pfm_ax_t st_d;

    always_comb begin
        st_d     = st_q;
        st_d.a   = sens_a;
        st_d.b   = sens_b;
        st_d.ovl = sens_a && sens_b;
        // a sensor that becomes blocked while its partner stays clear marks order
        st_d.bf  = sens_b && !st_q.b && !sens_a && !st_q.a;
        st_d.af  = sens_a && !st_q.a && !sens_b && !st_q.b;
        st_d.stk = 1'b0;
        if (!motor_on || sens_a != st_q.a || sens_b != st_q.b) begin
            st_d.cnt = '0;
        end else if (st_q.cnt >= STUCK_CYCLES - 1) begin
            st_d.stk = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign overlap = st_q.ovl;
    assign stuck   = st_q.stk;
    assign b_first = st_q.bf;
    assign a_first = st_q.af;
endmodule : pfm_axis_mon

// ### design/pfm_fault_mon.sv
// pfm_fault_mon: fault supervisor of the positioner board; latches the first
// fault as unit,number and stops all motion. pins are asynchronous.
// Operation
// - every reported code names unit two in its first field
// - both pan sensors blocked gives 2,01
// - left tilt commanded for stuck interval, no sensor change gives 2,02
// - right tilt commanded for stuck interval, no sensor change gives 2,03
// - pan commanded for stuck interval, no sensor change gives 2,04
// - no positioner transmission within timeout gives 2,07
// - invalid positioner message gives 2,08
// - left tilt down blocked before up gives 2,09
// - left tilt up blocked before down gives 2,10
// - right tilt down blocked before up gives 2,11
// - right tilt up blocked before down gives 2,12
// - left pan blocked before right gives 2,13
// - right pan blocked before left gives 2,14
// - both left tilt sensors blocked gives 2,15
// - both right tilt sensors blocked gives 2,16
// - code is one digit board number plus two digit fault number
// - any fault stops all motion and holds until power loss
`timescale 1ns/1ps
module pfm_fault_mon
    import pfm_pkg::*;
#(
    parameter int unsigned STUCK_CYCLES = STUCK_CYC,
    parameter int unsigned COMM_CYCLES  = COMM_TMO_CYC
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic                     pan_left_blk,
    input  wire logic                     pan_right_blk,
    input  wire logic                     ltilt_up_blk,
    input  wire logic                     ltilt_dn_blk,
    input  wire logic                     rtilt_up_blk,
    input  wire logic                     rtilt_dn_blk,
    input  wire logic                     pan_cmd,
    input  wire logic                     ltilt_cmd,
    input  wire logic                     rtilt_cmd,
    input  wire logic                     link_activity,
    input  wire logic                     link_msg_bad,
    output logic                          motion_en,
    output logic                          fault_valid,
    output logic [pfm_pkg::UNIT_W-1:0]    fault_unit,
    output logic [pfm_pkg::NUM_W-1:0]     fault_num
);
    localparam int unsigned NPIN    = 11;
    // slots of the synchroniser vector; sensors pair up per axis from the bottom
    localparam int unsigned P_PAN_L = 0;
    localparam int unsigned P_PAN_R = 1;
    localparam int unsigned P_LT_UP = 2;
    localparam int unsigned P_LT_DN = 3;
    localparam int unsigned P_RT_UP = 4;
    localparam int unsigned P_RT_DN = 5;
    localparam int unsigned P_PAN_C = 6;
    localparam int unsigned P_LT_C  = 7;
    localparam int unsigned P_RT_C  = 8;
    localparam int unsigned P_ACT   = 9;
    localparam int unsigned P_BAD   = 10;
    localparam int unsigned NAX     = 3;
    localparam int unsigned AX_PAN  = 0;
    localparam int unsigned AX_LT   = 1;
    localparam int unsigned AX_RT   = 2;

    typedef struct packed {
        logic [NPIN-1:0]   s1;
        logic [NPIN-1:0]   s2;
        logic              act_q;
        logic              bad_q;
        logic [CNT_W-1:0]  tmo;
        pfm_state_t        fsm;
        logic              vld;
        logic [UNIT_W-1:0] unit;
        logic [NUM_W-1:0]  num;
        logic              men;
    } pfm_top_t;

    pfm_top_t st_q;
    pfm_top_t st_d;

    logic [NPIN-1:0]  pins;
    logic [NAX-1:0]   ovl;
    logic [NAX-1:0]   stk;
    logic [NAX-1:0]   bf;
    logic [NAX-1:0]   af;
    logic [NAX-1:0]   cmd_s;
    logic [NUM_W-1:0] det;

    assign pins[P_PAN_L] = pan_left_blk;
    assign pins[P_PAN_R] = pan_right_blk;
    assign pins[P_LT_UP] = ltilt_up_blk;
    assign pins[P_LT_DN] = ltilt_dn_blk;
    assign pins[P_RT_UP] = rtilt_up_blk;
    assign pins[P_RT_DN] = rtilt_dn_blk;
    assign pins[P_PAN_C] = pan_cmd;
    assign pins[P_LT_C]  = ltilt_cmd;
    assign pins[P_RT_C]  = rtilt_cmd;
    assign pins[P_ACT]   = link_activity;
    assign pins[P_BAD]   = link_msg_bad;
    // motors are gated off at the monitor so a halted motor cannot look stuck
    assign cmd_s = st_q.s2[P_PAN_C +: NAX] & {NAX{st_q.men}};

    // axis 0 pan (a=left,b=right), 1 left tilt (a=up,b=down), 2 right tilt
    genvar g;
    generate
        for (g = 0; g < NAX; g++) begin : g_axis
            pfm_axis_mon #(
                .STUCK_CYCLES (STUCK_CYCLES)
            ) u_axis (
                .sys_clk  (sys_clk),
                .rst_n    (rst_n),
                .sens_a   (st_q.s2[2*g]),
                .sens_b   (st_q.s2[2*g+1]),
                .motor_on (cmd_s[g]),
                .overlap  (ovl[g]),
                .stuck    (stk[g]),
                .b_first  (bf[g]),
                .a_first  (af[g])
            );
        end
    endgenerate

    // one flag per fault so each rule sits on a line of its own
    logic c_pan_ovl;
    logic c_lt_stuck;
    logic c_rt_stuck;
    logic c_pan_stuck;
    logic c_tmo;
    logic c_bad;
    logic c_lt_up;
    logic c_lt_dn;
    logic c_rt_up;
    logic c_rt_dn;
    logic c_pan_right;
    logic c_pan_left;
    logic c_lt_ovl;
    logic c_rt_ovl;

    assign c_pan_ovl   = ovl[AX_PAN];
    assign c_lt_stuck  = stk[AX_LT];
    assign c_rt_stuck  = stk[AX_RT];
    assign c_pan_stuck = stk[AX_PAN];
    // the silence counter saturates, so a dead link keeps this flag raised
    assign c_tmo       = st_q.tmo >= COMM_CYCLES - 1;
    assign c_bad       = st_q.bad_q;
    assign c_lt_up     = bf[AX_LT];
    assign c_lt_dn     = af[AX_LT];
    assign c_rt_up     = bf[AX_RT];
    assign c_rt_dn     = af[AX_RT];
    assign c_pan_right = af[AX_PAN];
    assign c_pan_left  = bf[AX_PAN];
    assign c_lt_ovl    = ovl[AX_LT];
    assign c_rt_ovl    = ovl[AX_RT];

    // fixed priority only breaks ties inside a single cycle
    always_comb begin
        det = F_NONE;
        if (c_pan_ovl)           det = F_PAN_OVL;
        else if (c_lt_stuck)     det = F_LTILT_STUCK;
        else if (c_rt_stuck)     det = F_RTILT_STUCK;
        else if (c_pan_stuck)    det = F_PAN_STUCK;
        else if (c_tmo)          det = F_COMM_TMO;
        else if (c_bad)          det = F_COMM_BAD;
        else if (c_lt_up)        det = F_LTILT_UP;
        else if (c_lt_dn)        det = F_LTILT_DN;
        else if (c_rt_up)        det = F_RTILT_UP;
        else if (c_rt_dn)        det = F_RTILT_DN;
        else if (c_pan_right)    det = F_PAN_RIGHT;
        else if (c_pan_left)     det = F_PAN_LEFT;
        else if (c_lt_ovl)       det = F_LTILT_OVL;
        else if (c_rt_ovl)       det = F_RTILT_OVL;
    end

    always_comb begin
        st_d       = st_q;
        st_d.s1    = pins;
        st_d.s2    = st_q.s1;
        st_d.act_q = st_q.s2[P_ACT];
        // a bad flag only counts while the link is actually sending
        st_d.bad_q = st_q.s2[P_BAD] && st_q.s2[P_ACT];
        // rising edge of activity restarts the silence counter
        if (st_q.s2[P_ACT] && !st_q.act_q) begin
            st_d.tmo = '0;
        end else if (st_q.tmo < COMM_CYCLES - 1) begin
            st_d.tmo = st_q.tmo + CNT_W'(1);
        end
        case (st_q.fsm)
            PFM_RUN: begin
                st_d.men = 1'b1;
                if (det != F_NONE) begin
                    st_d.vld  = 1'b1;
                    st_d.unit = UNIT_NUM;
                    st_d.num = det;
                    st_d.fsm = PFM_FAULT;
                    st_d.men = 1'b0;
                end
            end
            PFM_FAULT: begin
                st_d.men = 1'b0;
            end
            default: begin
                st_d.fsm  = PFM_FAULT;
                st_d.vld  = 1'b1;
                st_d.unit = UNIT_NUM;
                st_d.men = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign motion_en   = st_q.men;
    // every output is a register so no decode glitch reaches the pins
    assign fault_valid = st_q.vld;
    assign fault_unit  = st_q.unit;
    assign fault_num   = st_q.num;
endmodule : pfm_fault_mon

// ### design/pfm_pkg.sv
// pfm_pkg: fault codes, timing constants and types for the positioner fault monitor.
// assumes a single 200 MHz system clock; no software-visible registers.
package pfm_pkg;
    localparam int unsigned UNIT_W        = 4;
    localparam int unsigned NUM_W         = 8;
    localparam logic [3:0]  UNIT_NUM      = 4'h2;
    localparam logic [7:0]  F_NONE        = 8'h00;
    localparam logic [7:0]  F_PAN_OVL     = 8'h01;
    localparam logic [7:0]  F_LTILT_STUCK = 8'h02;
    localparam logic [7:0]  F_RTILT_STUCK = 8'h03;
    localparam logic [7:0]  F_PAN_STUCK   = 8'h04;
    localparam logic [7:0]  F_COMM_TMO    = 8'h07;
    localparam logic [7:0]  F_COMM_BAD    = 8'h08;
    localparam logic [7:0]  F_LTILT_UP    = 8'h09;
    localparam logic [7:0]  F_LTILT_DN    = 8'h10;
    localparam logic [7:0]  F_RTILT_UP    = 8'h11;
    localparam logic [7:0]  F_RTILT_DN    = 8'h12;
    localparam logic [7:0]  F_PAN_RIGHT   = 8'h13;
    localparam logic [7:0]  F_PAN_LEFT    = 8'h14;
    localparam logic [7:0]  F_LTILT_OVL   = 8'h15;
    localparam logic [7:0]  F_RTILT_OVL   = 8'h16;

    localparam int unsigned CLK_MHZ       = 200;
    localparam int unsigned STUCK_MS      = 2000;
    localparam int unsigned COMM_TMO_MS   = 500;
    localparam int unsigned STUCK_CYC     = STUCK_MS * CLK_MHZ * 1000;
    localparam int unsigned COMM_TMO_CYC  = COMM_TMO_MS * CLK_MHZ * 1000;
    localparam int unsigned CNT_W         = 32;

    typedef enum logic [1:0] {
        PFM_RUN   = 2'b00,
        PFM_FAULT = 2'b01
    } pfm_state_t;
endpackage : pfm_pkg

// ### test/pfm_fault_mon_tb.sv
// pfm_fault_mon_tb: drives sensors, motor commands and link; checks codes.
// assumes short stuck and timeout counts set here.
`timescale 1ns/1ps
module pfm_fault_mon_tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] blk = 6'h00;
    logic [2:0] cmd = 3'h0;
    logic quiet = 1'b0;
    logic bad = 1'b0;
    logic act, msg_bad, motion_en, fault_valid;
    logic [3:0] fault_unit;
    logic [7:0] fault_num;
    int n_errors = 0;
    int comparisons = 0;
    always #2.5 sys_clk = ~sys_clk;
    pfm_link_model pfm_link_model_inst (.sys_clk(sys_clk), .rst_n(rst_n), .quiet(quiet),
        .bad(bad), .link_activity(act), .link_msg_bad(msg_bad));
    pfm_fault_mon #(.STUCK_CYCLES(50), .COMM_CYCLES(100)) pfm_fault_mon_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .pan_left_blk(blk[0]), .pan_right_blk(blk[1]),
        .ltilt_up_blk(blk[2]), .ltilt_dn_blk(blk[3]), .rtilt_up_blk(blk[4]),
        .rtilt_dn_blk(blk[5]), .pan_cmd(cmd[0]), .ltilt_cmd(cmd[1]), .rtilt_cmd(cmd[2]),
        .link_activity(act), .link_msg_bad(msg_bad), .motion_en(motion_en),
        .fault_valid(fault_valid), .fault_unit(fault_unit), .fault_num(fault_num));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic do_reset();
        @(posedge sys_clk);
        {blk, cmd, quiet, bad, rst_n} <= '0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        chk("motion_en", 8'h01, {7'h0, motion_en});
        chk("fault_valid", 8'h00, {7'h0, fault_valid});
        @(posedge sys_clk);
    endtask : do_reset
    task automatic expect_fault(input logic [7:0] code, input int lim);
        for (int i = 0; i < lim && fault_valid !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        chk("fault_unit", 8'h02, {4'h0, fault_unit});
        chk("fault_num", code, fault_num);
        chk("motion_en", 8'h00, {7'h0, motion_en});
    endtask : expect_fault
    task automatic overlap_case();
        logic [7:0] ovl [3] = '{8'h01, 8'h15, 8'h16};
        for (int k = 0; k < 3; k++) begin
            do_reset();
            blk <= 6'h03 << (2 * k);
            expect_fault(ovl[k], 10);
        end
    endtask : overlap_case
    task automatic order_case();
        logic [7:0] ord [6] = '{8'h13, 8'h14, 8'h10, 8'h09, 8'h12, 8'h11};
        for (int k = 0; k < 6; k++) begin
            do_reset();
            blk <= 6'h01 << k;
            expect_fault(ord[k], 10);
        end
    endtask : order_case
    task automatic stuck_case();
        logic [7:0] stk [3] = '{8'h04, 8'h02, 8'h03};
        for (int k = 0; k < 3; k++) begin
            do_reset();
            cmd <= 3'h1 << k;
            repeat (40) @(posedge sys_clk);
            #1;
            chk("early stuck", 8'h00, {7'h0, fault_valid});
            expect_fault(stk[k], 30);
        end
    endtask : stuck_case
    task automatic comm_case();
        do_reset();
        quiet <= 1'b1;
        repeat (70) @(posedge sys_clk);
        #1;
        chk("early timeout", 8'h00, {7'h0, fault_valid});
        expect_fault(8'h07, 60);
        do_reset();
        bad <= 1'b1;
        expect_fault(8'h08, 30);
    endtask : comm_case
    task automatic first_wins_case();
        do_reset();
        blk <= 6'h01;
        expect_fault(8'h13, 10);
        @(posedge sys_clk);
        // a later overlap and stuck motor must not replace the held code
        blk <= 6'h3f;
        cmd <= 3'h7;
        repeat (80) @(posedge sys_clk);
        #1;
        expect_fault(8'h13, 1);
    endtask : first_wins_case
    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    initial begin
        #25000;
        n_errors++;
        summarize();
    end
    initial begin
        overlap_case();
        order_case();
        stuck_case();
        comm_case();
        first_wins_case();
        summarize();
    end
endmodule : pfm_fault_mon_tb

// ### test/pfm_fault_monitor.sv
// pfm_fault_monitor: concurrent checks on the fault monitor pins.
// assumes one clock domain, sys_clk with async rst_n.
`timescale 1ns/1ps
module pfm_fault_monitor #(
    parameter int unsigned COMM_CYCLES = 100
) (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       pan_left_blk,
    input wire logic       pan_right_blk,
    input wire logic       ltilt_up_blk,
    input wire logic       ltilt_dn_blk,
    input wire logic       rtilt_up_blk,
    input wire logic       rtilt_dn_blk,
    input wire logic       link_activity,
    input wire logic       link_msg_bad,
    input wire logic       motion_en,
    input wire logic       fault_valid,
    input wire logic [3:0] fault_unit,
    input wire logic [7:0] fault_num
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    int unsigned quiet_q;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            quiet_q <= 0;
        end else if (link_activity) begin
            quiet_q <= 0;
        end else begin
            quiet_q <= quiet_q + 1;
        end
    end
    property p_unit; fault_valid |-> fault_unit == 4'h2; endproperty
    a_unit: assert property (p_unit) else $error("unit digit wrong");
    property p_bcd; $rose(fault_valid) |-> fault_num != 8'h00 && fault_num[3:0] < 4'ha
        && fault_num[7:4] < 4'ha; endproperty
    a_bcd: assert property (p_bcd) else $error("fault number not bcd");
    property p_stop; fault_valid |-> !motion_en; endproperty
    a_stop: assert property (p_stop) else $error("motion with fault");
    property p_hold; fault_valid |=> fault_valid && $stable(fault_num); endproperty
    a_hold: assert property (p_hold) else $error("fault not held");
    property p_pan_ovl; pan_left_blk && pan_right_blk |-> ##[1:6] fault_valid; endproperty
    a_pan_ovl: assert property (p_pan_ovl) else $error("pan overlap missed");
    property p_lt_ovl; ltilt_up_blk && ltilt_dn_blk |-> ##[1:6] fault_valid; endproperty
    a_lt_ovl: assert property (p_lt_ovl) else $error("left overlap missed");
    property p_rt_ovl; rtilt_up_blk && rtilt_dn_blk |-> ##[1:6] fault_valid; endproperty
    a_rt_ovl: assert property (p_rt_ovl) else $error("right overlap missed");
    property p_bad; link_activity && link_msg_bad |-> ##[1:8] fault_valid; endproperty
    a_bad: assert property (p_bad) else $error("bad message missed");
    property p_tmo; quiet_q > COMM_CYCLES + 8 |-> fault_valid; endproperty
    a_tmo: assert property (p_tmo) else $error("link timeout missed");
endmodule : pfm_fault_monitor
bind pfm_fault_mon pfm_fault_monitor #(.COMM_CYCLES(COMM_CYCLES)) u_mon (
    .sys_clk(sys_clk), .rst_n(rst_n), .pan_left_blk(pan_left_blk),
    .pan_right_blk(pan_right_blk), .ltilt_up_blk(ltilt_up_blk), .ltilt_dn_blk(ltilt_dn_blk),
    .rtilt_up_blk(rtilt_up_blk), .rtilt_dn_blk(rtilt_dn_blk), .link_activity(link_activity),
    .link_msg_bad(link_msg_bad), .motion_en(motion_en), .fault_valid(fault_valid),
    .fault_unit(fault_unit), .fault_num(fault_num));

// ### test/pfm_link_model.sv
// pfm_link_model: positioner side of the serial link, activity and bad flag.
// assumes the bench's sys_clk and rst_n.
`timescale 1ns/1ps
module pfm_link_model (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic quiet,
    input  wire logic bad,
    output logic      link_activity,
    output logic      link_msg_bad
);
    logic [3:0] slot_q;
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n) slot_q <= 4'h0;
        else slot_q <= slot_q + 4'h1;
    // short burst every 16 cycles; quiet lets the timeout run out
    assign link_activity = !quiet && rst_n && slot_q[3:2] == 2'b00;
    assign link_msg_bad  = bad && link_activity;
endmodule : pfm_link_model
